// File: include/cpsd_pkg.sv
// Shared constants and types for the program-counter, stack, flag and port datapath
// and for the sequencer that drives its strobes.
// Assumes both ends run on the same clock, core_clk_i.
package cpsd_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned WORD_W = 12;
  localparam int unsigned FLAG_W = 3;
  localparam int unsigned PORT_COUNT = 3;
  localparam int unsigned STACK_DEPTH = 2;
  localparam int unsigned STACK_PTR_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  // ==========================================================================
  // Counter source select codes
  localparam logic [1:0] SRC_STACK = 2'h0;
  localparam logic [1:0] SRC_ALU = 2'h1;
  localparam logic [1:0] SRC_LITERAL = 2'h2;

  // ==========================================================================
  // Special register addresses
  localparam logic [2:0] SFR_INDIRECT_ACCESS = 3'h0;
  localparam logic [2:0] SFR_TIMER_ZERO = 3'h1;
  localparam logic [2:0] SFR_COUNTER_LOW_BYTE = 3'h2;
  localparam logic [2:0] SFR_ALU_FLAGS = 3'h3;
  localparam logic [2:0] SFR_INDIRECT_POINTER = 3'h4;
  localparam logic [2:0] SFR_IO_PORT_FIRST = 3'h5;
  localparam logic [2:0] SFR_IO_PORT_SECOND = 3'h6;
  localparam logic [2:0] SFR_IO_PORT_THIRD = 3'h7;

  // ==========================================================================
  // Flag bit positions and reset values
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_DIGIT_CARRY = 1;
  localparam int unsigned FLAG_ZERO = 2;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PORT_OUT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
  localparam logic [ADDR_W-1:0] COUNTER_RESET = 9'h000;
  localparam logic [WORD_W-1:0] NOP_WORD = 12'h000;

  // ==========================================================================
  // Sequencer commands and states
  typedef enum logic [1:0] {
    CPSD_CMD_PLAIN = 2'b00,
    CPSD_CMD_JUMP = 2'b01,
    CPSD_CMD_CALL = 2'b10,
    CPSD_CMD_RETURN = 2'b11
  } cpsd_cmd_t;

  typedef enum logic [2:0] {
    CPSD_ST_IDLE = 3'b000,
    CPSD_ST_PLAIN = 3'b001,
    CPSD_ST_BRANCH_1 = 3'b010,
    CPSD_ST_BRANCH_2 = 3'b011,
    CPSD_ST_RETURN_1 = 3'b100,
    CPSD_ST_RETURN_2 = 3'b101,
    CPSD_ST_RETURN_3 = 3'b110
  } cpsd_state_t;

endpackage : cpsd_pkg

// File: include/cpsd_link_if.sv
// Strobe and status link between the sequencer and the datapath.
// Assumes the sequencer changes every strobe only right after a core_clk_i rising edge.
`timescale 1ns/10ps
`default_nettype none
interface cpsd_link_if;
  import cpsd_pkg::*;

  logic [1:0] counter_source_select;
  logic counter_load;
  logic counter_increment;
  logic counter_low_load;
  logic stack_load;
  logic stack_decrement;
  logic stack_increment;
  logic instruction_load;
  logic program_mux_select;
  logic carry_update;
  logic digit_carry_update;
  logic zero_update;
  logic flags_parallel_load;
  logic [PORT_COUNT-1:0] port_out_load;
  logic [PORT_COUNT-1:0] port_dir_load;
  logic [WORD_W-1:0] instruction_word;

  modport datapath (
    input counter_source_select, counter_load, counter_increment, counter_low_load,
    input stack_load, stack_decrement, stack_increment, instruction_load, program_mux_select,
    input carry_update, digit_carry_update, zero_update, flags_parallel_load,
    input port_out_load, port_dir_load,
    output instruction_word
  );

  modport sequencer (
    output counter_source_select, counter_load, counter_increment, counter_low_load,
    output stack_load, stack_decrement, stack_increment, instruction_load, program_mux_select,
    output carry_update, digit_carry_update, zero_update, flags_parallel_load,
    output port_out_load, port_dir_load,
    input instruction_word
  );
endinterface : cpsd_link_if
`default_nettype wire

// File: rtl/cpsd_datapath.sv
// Program counter, return stack, flag register, three bidirectional ports,
// special register read multiplexer and instruction register with skip substitution.
// Assumes strobes on the link come from logic on core_clk_i; port pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none

module cpsd_datapath (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  cpsd_link_if.datapath link,
  input wire logic [cpsd_pkg::DATA_W-1:0] alu_bus_i,
  input wire logic [cpsd_pkg::FLAG_W-1:0] flag_bus_i,
  input wire logic [cpsd_pkg::WORD_W-1:0] program_word_i,
  input wire logic [2:0] sfr_read_addr_i,
  input wire logic [cpsd_pkg::DATA_W-1:0] indirect_pointer_i,
  input wire logic [cpsd_pkg::PORT_COUNT*cpsd_pkg::DATA_W-1:0] port_pin_i,
  output logic [cpsd_pkg::PORT_COUNT*cpsd_pkg::DATA_W-1:0] port_pin_o,
  output logic [cpsd_pkg::PORT_COUNT*cpsd_pkg::DATA_W-1:0] port_pin_oe_o,
  output logic [cpsd_pkg::ADDR_W-1:0] program_address_o,
  output logic [cpsd_pkg::ADDR_W-1:0] stack_top_o,
  output logic [cpsd_pkg::DATA_W-1:0] flags_o,
  output logic [cpsd_pkg::DATA_W-1:0] sfr_data_bus_o
);
  import cpsd_pkg::*;

  // ==========================================================================
  // Declarations
  logic [ADDR_W-1:0] counter_reg;
  logic [ADDR_W-1:0] counter_source_bus;
  logic [ADDR_W-1:0] stack_mem [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] stack_ptr_reg;
  logic [ADDR_W-1:0] stack_bus;
  logic [WORD_W-1:0] instruction_reg;
  logic [WORD_W-1:0] program_mux_bus;
  logic [DATA_W-1:0] flags_reg;
  logic [DATA_W-1:0] port_out_reg [PORT_COUNT];
  logic [DATA_W-1:0] port_dir_reg [PORT_COUNT];
  logic [DATA_W-1:0] pin_meta_reg [PORT_COUNT];
  logic [DATA_W-1:0] pin_sync_reg [PORT_COUNT];
  logic [DATA_W-1:0] sfr_data_next;

  // ==========================================================================
  // Counter source multiplexer
  always_comb
  begin
    case (link.counter_source_select)
      SRC_STACK: counter_source_bus = stack_bus;
      SRC_ALU: counter_source_bus = {1'b0, alu_bus_i};
      SRC_LITERAL: counter_source_bus = instruction_reg[ADDR_W-1:0];
      default: counter_source_bus = stack_bus;
    endcase
  end

  // ==========================================================================
  // Program counter
  // Full load wins over a low-byte write, which wins over the increment
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      counter_reg <= COUNTER_RESET;
    end
    else if (link.counter_load)
    begin
      counter_reg <= counter_source_bus;
    end
    else if (link.counter_low_load)
    begin
      counter_reg <= {counter_reg[ADDR_W-1], alu_bus_i};
    end
    else if (link.counter_increment)
    begin
      counter_reg <= counter_reg + 9'h001;
    end
  end

  // ==========================================================================
  // Return stack
  assign stack_bus = stack_mem[stack_ptr_reg];

  always_ff @(posedge core_clk_i)
  begin
    if (link.stack_load)
    begin
      stack_mem[stack_ptr_reg] <= counter_reg;
    end
  end

  // Pointer wraps around the depth; both directions given, decrement wins
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      stack_ptr_reg <= '0;
    end
    else if (link.stack_decrement)
    begin
      if (stack_ptr_reg == '0)
      begin
        stack_ptr_reg <= STACK_PTR_W'(STACK_DEPTH - 1);
      end
      else
      begin
        stack_ptr_reg <= stack_ptr_reg - 1'b1;
      end
    end
    else if (link.stack_increment)
    begin
      if (stack_ptr_reg == STACK_PTR_W'(STACK_DEPTH - 1))
      begin
        stack_ptr_reg <= '0;
      end
      else
      begin
        stack_ptr_reg <= stack_ptr_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Instruction register with skip substitution
  assign program_mux_bus = link.program_mux_select ? NOP_WORD : program_word_i;

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      instruction_reg <= NOP_WORD;
    end
    else if (link.instruction_load)
    begin
      instruction_reg <= program_mux_bus;
    end
  end

  // ==========================================================================
  // Flag register
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      flags_reg <= FLAGS_RESET;
    end
    else if (link.flags_parallel_load)
    begin
      flags_reg <= alu_bus_i;
    end
    else
    begin
      if (link.carry_update)
      begin
        flags_reg[FLAG_CARRY] <= flag_bus_i[FLAG_CARRY];
      end
      if (link.digit_carry_update)
      begin
        flags_reg[FLAG_DIGIT_CARRY] <= flag_bus_i[FLAG_DIGIT_CARRY];
      end
      if (link.zero_update)
      begin
        flags_reg[FLAG_ZERO] <= flag_bus_i[FLAG_ZERO];
      end
    end
  end

  // ==========================================================================
  // Bidirectional ports
  generate
    for (genvar p = 0; p < PORT_COUNT; p++)
    begin : g_port
      always_ff @(posedge core_clk_i)
      begin
        if (!rstn_i)
        begin
          port_out_reg[p] <= PORT_OUT_RESET;
        end
        else if (link.port_out_load[p])
        begin
          port_out_reg[p] <= alu_bus_i;
        end
      end

      always_ff @(posedge core_clk_i)
      begin
        if (!rstn_i)
        begin
          port_dir_reg[p] <= DIR_RESET;
        end
        else if (link.port_dir_load[p])
        begin
          port_dir_reg[p] <= alu_bus_i;
        end
      end

      always_ff @(posedge core_clk_i)
      begin
        pin_meta_reg[p] <= port_pin_i[p*DATA_W +: DATA_W];
        pin_sync_reg[p] <= pin_meta_reg[p];
      end

      assign port_pin_o[p*DATA_W +: DATA_W] = port_out_reg[p];
      assign port_pin_oe_o[p*DATA_W +: DATA_W] = ~port_dir_reg[p];
    end
  endgenerate

  // ==========================================================================
  // Special register read multiplexer
  always_comb
  begin
    case (sfr_read_addr_i)
      SFR_INDIRECT_ACCESS: sfr_data_next = 8'h00;
      SFR_TIMER_ZERO: sfr_data_next = 8'h00;
      SFR_COUNTER_LOW_BYTE: sfr_data_next = counter_reg[DATA_W-1:0];
      SFR_ALU_FLAGS: sfr_data_next = flags_reg;
      SFR_INDIRECT_POINTER: sfr_data_next = indirect_pointer_i;
      SFR_IO_PORT_FIRST: sfr_data_next = pin_sync_reg[0];
      SFR_IO_PORT_SECOND: sfr_data_next = pin_sync_reg[1];
      SFR_IO_PORT_THIRD: sfr_data_next = pin_sync_reg[2];
      default: sfr_data_next = 8'h00;
    endcase
  end

  assign sfr_data_bus_o = sfr_data_next;
  assign program_address_o = counter_reg;
  assign stack_top_o = stack_bus;
  assign flags_o = flags_reg;
  assign link.instruction_word = instruction_reg;

endmodule // cpsd_datapath
`default_nettype wire

// File: rtl/cpsd_sequencer.sv
// Sequencer end: turns one command into the strobe pattern for plain,
// jump, call and return-with-literal instructions.
// Assumes the datapath samples every strobe at the next core_clk_i rising edge.
`timescale 1ns/10ps
`default_nettype none
module cpsd_sequencer (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  cpsd_link_if.sequencer link,
  input wire logic cmd_valid_i,
  input wire cpsd_pkg::cpsd_cmd_t cmd_kind_i,
  input wire logic cmd_skip_i,
  input wire logic cmd_write_i,
  input wire logic [2:0] cmd_target_i,
  input wire logic cmd_dir_i,
  input wire logic [1:0] cmd_dir_port_i,
  input wire logic [cpsd_pkg::FLAG_W-1:0] cmd_flag_mask_i,
  output logic cmd_ready_o,
  output logic w_load_o
);
  import cpsd_pkg::*;

  // ==========================================================================
  // Command capture and state
  cpsd_state_t state_reg;
  cpsd_state_t state_next;
  logic jump_reg;
  logic skip_reg;
  logic write_reg;
  logic [2:0] target_reg;
  logic dir_reg;
  logic [1:0] dir_port_reg;
  logic [FLAG_W-1:0] flag_mask_reg;
  logic in_plain;
  logic in_b1;
  logic in_b2;

  assign cmd_ready_o = (state_reg == CPSD_ST_IDLE);

  always_comb
  begin
    case (state_reg)
      CPSD_ST_IDLE:
      begin
        if (!cmd_valid_i)
        begin
          state_next = CPSD_ST_IDLE;
        end
        else if (cmd_kind_i == CPSD_CMD_PLAIN)
        begin
          state_next = CPSD_ST_PLAIN;
        end
        else if (cmd_kind_i == CPSD_CMD_RETURN)
        begin
          state_next = CPSD_ST_RETURN_1;
        end
        else
        begin
          state_next = CPSD_ST_BRANCH_1;
        end
      end
      CPSD_ST_BRANCH_1: state_next = CPSD_ST_BRANCH_2;
      CPSD_ST_RETURN_1: state_next = CPSD_ST_RETURN_2;
      CPSD_ST_RETURN_2: state_next = CPSD_ST_RETURN_3;
      default: state_next = CPSD_ST_IDLE;
    endcase
  end

  // Strobes are decoded from state registered at the rising edge
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= CPSD_ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      jump_reg <= 1'b0;
      skip_reg <= 1'b0;
      write_reg <= 1'b0;
      target_reg <= 3'h0;
      dir_reg <= 1'b0;
      dir_port_reg <= 2'h0;
      flag_mask_reg <= '0;
    end
    else if (cmd_ready_o && cmd_valid_i)
    begin
      jump_reg <= (cmd_kind_i == CPSD_CMD_JUMP);
      skip_reg <= cmd_skip_i;
      write_reg <= cmd_write_i;
      target_reg <= cmd_target_i;
      dir_reg <= cmd_dir_i;
      dir_port_reg <= cmd_dir_port_i;
      flag_mask_reg <= cmd_flag_mask_i;
    end
  end

  // ==========================================================================
  // Strobe decode
  assign in_plain = (state_reg == CPSD_ST_PLAIN);
  assign in_b1 = (state_reg == CPSD_ST_BRANCH_1);
  assign in_b2 = (state_reg == CPSD_ST_BRANCH_2);

  always_comb
  begin
    link.counter_source_select = SRC_STACK;
    if (in_b1)
    begin
      link.counter_source_select = jump_reg ? SRC_LITERAL : SRC_ALU;
    end
  end

  assign link.counter_load = in_b1 || (state_reg == CPSD_ST_RETURN_2);
  assign link.stack_load = in_b1 && !jump_reg;
  assign link.stack_decrement = (in_b2 && !jump_reg) || (state_reg == CPSD_ST_RETURN_1);
  assign link.stack_increment = 1'b0;
  assign link.instruction_load = in_plain || in_b2 || (state_reg == CPSD_ST_RETURN_3);
  assign link.counter_increment = link.instruction_load;
  assign link.program_mux_select = link.instruction_load && skip_reg;
  assign w_load_o = (state_reg == CPSD_ST_RETURN_3);

  assign link.counter_low_load = in_plain && write_reg && (target_reg == SFR_COUNTER_LOW_BYTE);
  assign link.flags_parallel_load = in_plain && write_reg && (target_reg == SFR_ALU_FLAGS);
  assign link.carry_update = in_plain && flag_mask_reg[FLAG_CARRY];
  assign link.digit_carry_update = in_plain && flag_mask_reg[FLAG_DIGIT_CARRY];
  assign link.zero_update = in_plain && flag_mask_reg[FLAG_ZERO];

  generate
    for (genvar p = 0; p < PORT_COUNT; p++)
    begin : g_port
      assign link.port_out_load[p] = in_plain && write_reg && (target_reg == 3'(SFR_IO_PORT_FIRST + p));
      assign link.port_dir_load[p] = in_plain && dir_reg && (dir_port_reg == 2'(p));
    end
  endgenerate

endmodule // cpsd_sequencer
`default_nettype wire

// File: tb/cpsd_link_props.sv
// Concurrent checks on the sequencer-to-datapath link and the datapath outputs.
// Assumes one clock domain and instantiation beside the link interface in tb.
`timescale 1ns/10ps
`default_nettype none
module cpsd_link_props
  import cpsd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] counter_source_select,
  input wire logic counter_load,
  input wire logic counter_increment,
  input wire logic counter_low_load,
  input wire logic stack_load,
  input wire logic stack_decrement,
  input wire logic instruction_load,
  input wire logic carry_update,
  input wire logic flags_parallel_load,
  input wire logic [cpsd_pkg::WORD_W-1:0] instruction_word,
  input wire logic [cpsd_pkg::ADDR_W-1:0] program_address_o,
  input wire logic [cpsd_pkg::DATA_W-1:0] flags_o,
  input wire logic [cpsd_pkg::DATA_W-1:0] alu_bus_i,
  input wire logic [cpsd_pkg::FLAG_W-1:0] flag_bus_i,
  input wire logic w_load_o
);
  // ==========================================================================
  // Helpers
  logic [ADDR_W-1:0] literal;
  logic load_lit;
  logic load_alu;
  assign literal = instruction_word[ADDR_W-1:0];
  assign load_lit = counter_load && (counter_source_select == SRC_LITERAL);
  assign load_alu = counter_load && (counter_source_select == SRC_ALU);

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ==========================================================================
  // Counter
  property p_src_literal;
    load_lit |=> program_address_o == $past(literal);
  endproperty
  a_src_literal: assert property (p_src_literal) else $error("literal load mismatch");
  property p_src_alu;
    load_alu |=> program_address_o == {1'b0, $past(alu_bus_i)};
  endproperty
  a_src_alu: assert property (p_src_alu) else $error("alu load mismatch");
  property p_increment;
    counter_increment && !counter_load && !counter_low_load
      |=> program_address_o == $past(program_address_o) + 9'h001;
  endproperty
  a_increment: assert property (p_increment) else $error("increment mismatch");
  property p_low_byte;
    counter_low_load && !counter_load
      |=> program_address_o == {$past(program_address_o[ADDR_W-1]), $past(alu_bus_i)};
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte load mismatch");

  // ==========================================================================
  // Sequences
  property p_jump_seq;
    load_lit |=> instruction_load && !counter_load && !stack_load;
  endproperty
  a_jump_seq: assert property (p_jump_seq) else $error("jump sequence wrong");
  property p_call_seq;
    stack_load |-> load_alu ##1 (instruction_load && stack_decrement);
  endproperty
  a_call_seq: assert property (p_call_seq) else $error("call sequence wrong");
  property p_return_seq;
    stack_decrement && !instruction_load
      |=> (counter_load && counter_source_select == SRC_STACK) ##1 (instruction_load && w_load_o);
  endproperty
  a_return_seq: assert property (p_return_seq) else $error("return sequence wrong");

  // ==========================================================================
  // Flags
  property p_flags_parallel;
    flags_parallel_load |=> flags_o == $past(alu_bus_i);
  endproperty
  a_flags_parallel: assert property (p_flags_parallel) else $error("flag parallel load wrong");
  property p_carry;
    carry_update && !flags_parallel_load |=> flags_o[FLAG_CARRY] == $past(flag_bus_i[FLAG_CARRY]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry update wrong");
endmodule // cpsd_link_props
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench: sequencer and datapath joined by the link interface.
// Assumes a 100 ns clock; the program store is a fixed function of the address.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cpsd_pkg::*;
  // ==========================================================================
  // Signals
  logic core_clk_i, rstn_i, cmd_valid_i, cmd_skip_i, cmd_write_i, cmd_dir_i, cmd_ready_o, w_load_o;
  cpsd_cmd_t cmd_kind_i;
  logic [2:0] cmd_target_i, cmd_flag_mask_i, flag_bus_i, sfr_read_addr_i;
  logic [1:0] cmd_dir_port_i;
  logic [7:0] alu_bus_i, indirect_pointer_i, flags_o, sfr_data_bus_o;
  logic [11:0] program_word_i;
  logic [23:0] port_pin_i, port_pin_o, port_pin_oe_o, ext_pins;
  logic [8:0] program_address_o, stack_top_o, pc_exp, ret_addr;
  int err_count, samples_checked, cycles;

  function automatic logic [11:0] store_word(input logic [8:0] a);
    return {3'h5, ~a};
  endfunction
  assign program_word_i = store_word(program_address_o);
  // Pin level: driven bits from the port, the rest from the outside world
  assign port_pin_i = (port_pin_oe_o & port_pin_o) | (~port_pin_oe_o & ext_pins);

  cpsd_link_if link();
  cpsd_datapath cpsd_datapath_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link.datapath),
    .alu_bus_i(alu_bus_i), .flag_bus_i(flag_bus_i), .program_word_i(program_word_i),
    .sfr_read_addr_i(sfr_read_addr_i), .indirect_pointer_i(indirect_pointer_i), .port_pin_i(port_pin_i),
    .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o), .program_address_o(program_address_o),
    .stack_top_o(stack_top_o), .flags_o(flags_o), .sfr_data_bus_o(sfr_data_bus_o));
  cpsd_sequencer cpsd_sequencer_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link.sequencer),
    .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_skip_i(cmd_skip_i), .cmd_write_i(cmd_write_i),
    .cmd_target_i(cmd_target_i), .cmd_dir_i(cmd_dir_i), .cmd_dir_port_i(cmd_dir_port_i),
    .cmd_flag_mask_i(cmd_flag_mask_i), .cmd_ready_o(cmd_ready_o), .w_load_o(w_load_o));
  cpsd_link_props cpsd_link_props_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .counter_source_select(link.counter_source_select), .counter_load(link.counter_load),
    .counter_increment(link.counter_increment), .counter_low_load(link.counter_low_load),
    .stack_load(link.stack_load), .stack_decrement(link.stack_decrement),
    .instruction_load(link.instruction_load), .carry_update(link.carry_update),
    .flags_parallel_load(link.flags_parallel_load), .instruction_word(link.instruction_word),
    .program_address_o(program_address_o), .flags_o(flags_o), .alu_bus_i(alu_bus_i),
    .flag_bus_i(flag_bus_i), .w_load_o(w_load_o));

  // ==========================================================================
  // Clock and timeout
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_addr(input string what, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issues one command at a falling edge and returns at the falling edge where ready is back
  task automatic go(input cpsd_cmd_t k, input logic skip, input logic wr, input logic [2:0] tgt,
                    input logic dir, input logic [1:0] dp, input logic [2:0] mask,
                    input logic [7:0] alu, input logic [2:0] fl);
    int n;
    cmd_kind_i = k;
    cmd_skip_i = skip;
    cmd_write_i = wr;
    cmd_target_i = tgt;
    cmd_dir_i = dir;
    cmd_dir_port_i = dp;
    cmd_flag_mask_i = mask;
    alu_bus_i = alu;
    flag_bus_i = fl;
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 8)
    begin
      @(negedge core_clk_i);
      n++;
    end
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    logic [2:0] addrs [5];
    logic [7:0] vals [5];
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    rstn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_kind_i = CPSD_CMD_PLAIN;
    {cmd_skip_i, cmd_write_i, cmd_dir_i} = 3'h0;
    {cmd_target_i, cmd_flag_mask_i, flag_bus_i, sfr_read_addr_i} = 12'h000;
    cmd_dir_port_i = 2'h0;
    alu_bus_i = 8'h00;
    indirect_pointer_i = 8'h5a;
    ext_pins = 24'ha55a3c;
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    chk_addr("counter", COUNTER_RESET, program_address_o);
    chk_word("instruction", NOP_WORD, link.instruction_word);
    chk_byte("flags", FLAGS_RESET, flags_o);
    for (int p = 0; p < 3; p++)
      chk_byte("port oe", 8'h00, port_pin_oe_o[8*p +: 8]);
    $display("Test reset done");
    // The skip falls between two real fetches so a missing substitution shows
    pc_exp = 9'h000;
    for (int i = 0; i < 4; i++)
    begin
      go(CPSD_CMD_PLAIN, 1'(i == 1), 1'b0, 3'h0, 1'b0, 2'h0, 3'h0, 8'h00, 3'h0);
      if (i == 1)
        chk_word("skipped word", NOP_WORD, link.instruction_word);
      else
        chk_word("fetched word", store_word(pc_exp), link.instruction_word);
      pc_exp = pc_exp + 9'h001;
      chk_addr("counter", pc_exp, program_address_o);
    end
    $display("Test plain done");
    ret_addr = ~(pc_exp - 9'h001);
    go(CPSD_CMD_JUMP, 1'b0, 1'b0, 3'h0, 1'b0, 2'h0, 3'h0, 8'h00, 3'h0);
    chk_addr("jump counter", ret_addr + 9'h001, program_address_o);
    chk_word("jump word", store_word(ret_addr), link.instruction_word);
    ret_addr = ret_addr + 9'h001;
    go(CPSD_CMD_CALL, 1'b0, 1'b0, 3'h0, 1'b0, 2'h0, 3'h0, 8'h3c, 3'h0);
    chk_addr("call counter", 9'h03d, program_address_o);
    chk_word("call word", store_word(9'h03c), link.instruction_word);
    go(CPSD_CMD_RETURN, 1'b0, 1'b0, 3'h0, 1'b0, 2'h0, 3'h0, 8'h00, 3'h0);
    chk_addr("return counter", ret_addr + 9'h001, program_address_o);
    chk_word("return word", store_word(ret_addr), link.instruction_word);
    chk_addr("stack top", ret_addr, stack_top_o);
    pc_exp = ret_addr + 9'h001;
    go(CPSD_CMD_PLAIN, 1'b0, 1'b1, SFR_COUNTER_LOW_BYTE, 1'b0, 2'h0, 3'h0, 8'h77, 3'h0);
    chk_addr("low byte", {pc_exp[8], 8'h77}, program_address_o);
    $display("Test branch done");
    go(CPSD_CMD_PLAIN, 1'b0, 1'b0, 3'h0, 1'b0, 2'h0, 3'h7, 8'h00, 3'h5);
    chk_byte("flags", 8'h05, flags_o);
    go(CPSD_CMD_PLAIN, 1'b0, 1'b0, 3'h0, 1'b0, 2'h0, 3'h1, 8'h00, 3'h2);
    chk_byte("flags", 8'h04, flags_o);
    go(CPSD_CMD_PLAIN, 1'b0, 1'b1, SFR_ALU_FLAGS, 1'b0, 2'h0, 3'h7, 8'ha8, 3'h7);
    chk_byte("flags", 8'ha8, flags_o);
    $display("Test flags done");
    for (int p = 0; p < 3; p++)
    begin
      go(CPSD_CMD_PLAIN, 1'b0, 1'b1, SFR_IO_PORT_FIRST + 3'(p), 1'b0, 2'h0, 3'h0, 8'hc3 ^ 8'(p), 3'h0);
      go(CPSD_CMD_PLAIN, 1'b0, 1'b0, 3'h0, 1'b1, 2'(p), 3'h0, 8'h0f, 3'h0);
      chk_byte("port out", 8'hc3 ^ 8'(p), port_pin_o[8*p +: 8]);
      chk_byte("port oe", 8'hf0, port_pin_oe_o[8*p +: 8]);
      sfr_read_addr_i = SFR_IO_PORT_FIRST + 3'(p);
      repeat (3) @(negedge core_clk_i);
      chk_byte("port read", ((8'hc3 ^ 8'(p)) & 8'hf0) | (ext_pins[8*p +: 8] & 8'h0f), sfr_data_bus_o);
    end
    $display("Test ports done");
    // Counter sits at 180h after the low-byte write, three flag and six port commands
    addrs = '{SFR_INDIRECT_ACCESS, SFR_TIMER_ZERO, SFR_ALU_FLAGS, SFR_INDIRECT_POINTER, SFR_COUNTER_LOW_BYTE};
    vals = '{8'h00, 8'h00, 8'ha8, 8'h5a, 8'h80};
    for (int i = 0; i < 5; i++)
    begin
      sfr_read_addr_i = addrs[i];
      @(negedge core_clk_i);
      chk_byte("sfr read", vals[i], sfr_data_bus_o);
    end
    $display("Test sfr mux done");
    summarize();
  end
endmodule // tb
`default_nettype wire
